// >>> logic/tmsp_pkg.sv
// constants and types of the temperature monitor serial register port
package tmsp_pkg;

    // ************************************************************
    // bus address
    // ************************************************************
    localparam logic [6:0] DEV_ADDR_BASE = 7'h4c;
    localparam logic [6:0] DEV_ADDR_ALT = 7'h4d;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] RA_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] RA_REMOTE_HIGH = 8'h01;
    localparam logic [7:0] RA_CONDITION = 8'h02;
    localparam logic [7:0] RA_REMOTE_LOW = 8'h10;
    localparam logic [7:0] RA_MAKER = 8'hfe;
    localparam logic [7:0] RA_REVISION = 8'hff;
    localparam logic [7:0] WA_ONE_SHOT = 8'h0f;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // writable registers, slot 0 is device_setup .. slot 13 is fault_count_filter
    localparam int NUM_SLOTS = 14;
    localparam logic [13:0][7:0] SLOT_RD_ADDR = {8'h22, 8'h21, 8'h20, 8'h19, 8'h14, 8'h13, 8'h12,
                                                 8'h11, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03};
    localparam logic [13:0][7:0] SLOT_WR_ADDR = {8'h22, 8'h21, 8'h20, 8'h19, 8'h14, 8'h13, 8'h12,
                                                 8'h11, 8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h09};
    localparam logic [13:0][7:0] SLOT_RESET = {8'h01, 8'h0a, 8'h55, 8'h6c, 8'h00, 8'h00, 8'h00,
                                               8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h08, 8'h00};
    localparam int SLOT_FAULT_FILTER = 13;
    localparam int TIMEOUT_EN_BIT = 7;

    // arbitrary identity values
    localparam logic [7:0] MAKER_ID = 8'h5a;
    localparam logic [7:0] REVISION_ID = 8'h01;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (SYS_CLK_HZ / 1000);
    localparam int TO_CNT_W = 24;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ, ST_READ_ACK}
        tmsp_state_t;

    typedef logic [13:0][7:0] tmsp_cfg_t;

    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_high;
        logic [7:0] remote_low;
        logic [7:0] condition;
    } tmsp_meas_t;

    typedef struct packed {
        tmsp_state_t st;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic first;
        logic drive;
        logic [7:0] ptr;
        tmsp_cfg_t cfg;
        logic start_seen;
        logic stop_seen;
        logic [3:0] act_bin;
        logic [3:0] act_gray;
        logic os_tog;
        logic rel_s1;
        logic rel_s2;
        logic rel_done;
        logic sel_s1;
        logic sel_s2;
        tmsp_meas_t meas_s1;
        tmsp_meas_t meas_s2;
    } tmsp_link_t;

    typedef struct packed {
        logic [3:0] act_s1;
        logic [3:0] act_s2;
        logic [3:0] act_s3;
        logic en_s1;
        logic en_s2;
        logic os_s1;
        logic os_s2;
        logic os_s3;
        logic [TO_CNT_W-1:0] cnt;
        logic rel;
        logic one_shot;
    } tmsp_sys_t;

endpackage

// >>> logic/tmsp_port.sv
// two-wire serial slave port and register map of the temperature monitor
// Operation
// - answer only own fixed address, variant selectable
// - start is data falling while clock high
// - matching address acknowledged before ninth pulse
// - direction bit zero writes, one reads
// - each byte: eight bits plus acknowledge
// - data rising while clock high means stop
// - first written byte loads register pointer
// - second written byte goes to pointed register
// - read returns register at current pointer
// - separate read and write addresses respected
// - idle timeout releases data line
// - timeout off at reset, enabled by bit
// - remote reading split into read-only bytes
// - limits read and written at different addresses
// - power-on defaults for limits and rate
// - write to one-shot address starts conversion
`timescale 1ns/1ps
module tmsp_port #(
    parameter int TIMEOUT_CYC = tmsp_pkg::TIMEOUT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic addr_sel_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire tmsp_pkg::tmsp_meas_t meas_i,
    output tmsp_pkg::tmsp_cfg_t cfg_o,
    output logic one_shot_o
);

    // ************************************************************
    // start and stop capture on data edges
    // ************************************************************
    logic start_tog_q;
    logic stop_tog_q;
    logic bit_q;
    logic [6:0] own_addr;

    always_ff @(negedge sda_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            start_tog_q <= 1'b0;
        else if (scl_i)
            start_tog_q <= ~start_tog_q;
    end

    always_ff @(posedge sda_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            stop_tog_q <= 1'b0;
        else if (scl_i)
            stop_tog_q <= ~stop_tog_q;
    end

    // data sampled while the clock is high
    always_ff @(posedge scl_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            bit_q <= 1'b1;
        else
            bit_q <= sda_i;
    end

    // ************************************************************
    // link engine, advances on the falling clock edge
    // ************************************************************
    tmsp_pkg::tmsp_link_t l_q;
    tmsp_pkg::tmsp_link_t l_d;
    tmsp_pkg::tmsp_sys_t s_q;
    tmsp_pkg::tmsp_sys_t s_d;
    logic [7:0] shifted;
    logic [7:0] rd_byte;
    logic wr_hit;
    logic [3:0] wr_slot;
    logic rel_hit;
    localparam int TO_CNT_W = tmsp_pkg::TO_CNT_W;

    assign own_addr = l_q.sel_s2 ? tmsp_pkg::DEV_ADDR_ALT : tmsp_pkg::DEV_ADDR_BASE;
    // a release is acted on once, a new start consumes it
    assign rel_hit = l_q.rel_s2 & ~l_q.rel_done;

    // read mux on the pointer
    always_comb
    begin
        rd_byte = tmsp_pkg::RD_UNMAPPED;
        unique case (l_q.ptr)
            tmsp_pkg::RA_LOCAL_TEMP: rd_byte = l_q.meas_s2.local_temp;
            tmsp_pkg::RA_REMOTE_HIGH: rd_byte = l_q.meas_s2.remote_high;
            tmsp_pkg::RA_REMOTE_LOW: rd_byte = l_q.meas_s2.remote_low;
            tmsp_pkg::RA_CONDITION: rd_byte = l_q.meas_s2.condition;
            tmsp_pkg::RA_MAKER: rd_byte = tmsp_pkg::MAKER_ID;
            tmsp_pkg::RA_REVISION: rd_byte = tmsp_pkg::REVISION_ID;
            default:
            begin
                for (int i = 0; i < tmsp_pkg::NUM_SLOTS; i++)
                begin
                    if (l_q.ptr == tmsp_pkg::SLOT_RD_ADDR[i])
                        rd_byte = l_q.cfg[i];
                end
            end
        endcase
    end

    // write decode on the pointer
    always_comb
    begin
        wr_hit = 1'b0;
        wr_slot = 4'h0;
        for (int i = 0; i < tmsp_pkg::NUM_SLOTS; i++)
        begin
            if (l_q.ptr == tmsp_pkg::SLOT_WR_ADDR[i])
            begin
                wr_hit = 1'b1;
                wr_slot = 4'(i);
            end
        end
    end

    assign shifted = {l_q.sh[6:0], bit_q};

    always_comb
    begin
        l_d = l_q;
        l_d.meas_s1 = meas_i;
        l_d.meas_s2 = l_q.meas_s1;
        l_d.rel_s1 = s_q.rel;
        l_d.rel_s2 = l_q.rel_s1;
        l_d.sel_s1 = addr_sel_i;
        l_d.sel_s2 = l_q.sel_s1;
        // gray count of falling edges, safe to sample on the system clock
        l_d.act_bin = 4'(l_q.act_bin + 4'h1);
        l_d.act_gray = l_d.act_bin ^ {1'b0, l_d.act_bin[3:1]};
        if (!l_q.rel_s2)
            l_d.rel_done = 1'b0;
        if (start_tog_q != l_q.start_seen)
        begin
            l_d.start_seen = start_tog_q;
            l_d.rel_done = 1'b1;
            l_d.stop_seen = stop_tog_q;
            l_d.st = tmsp_pkg::ST_ADDR;
            l_d.cnt = 3'h0;
            l_d.drive = 1'b0;
            l_d.first = 1'b1;
        end
        else if (stop_tog_q != l_q.stop_seen || rel_hit)
        begin
            l_d.stop_seen = stop_tog_q;
            l_d.rel_done = l_q.rel_s2;
            l_d.st = tmsp_pkg::ST_IDLE;
            l_d.drive = 1'b0;
        end
        else
        begin
            unique case (l_q.st)
                tmsp_pkg::ST_IDLE:
                begin
                    l_d.drive = 1'b0;
                end
                tmsp_pkg::ST_ADDR:
                begin
                    l_d.sh = shifted;
                    if (l_q.cnt == tmsp_pkg::LAST_BIT)
                    begin
                        if (shifted[7:1] == own_addr)
                        begin
                            l_d.st = tmsp_pkg::ST_ACK_ADDR;
                            l_d.rw = shifted[0];
                            l_d.drive = 1'b1;
                        end
                        else
                        begin
                            l_d.st = tmsp_pkg::ST_IDLE;
                        end
                    end
                    else
                    begin
                        l_d.cnt = 3'(l_q.cnt + 3'h1);
                    end
                end
                tmsp_pkg::ST_ACK_ADDR:
                begin
                    l_d.cnt = 3'h0;
                    if (l_q.rw)
                    begin
                        l_d.st = tmsp_pkg::ST_READ;
                        l_d.tx = rd_byte;
                        l_d.drive = ~rd_byte[7];
                    end
                    else
                    begin
                        l_d.st = tmsp_pkg::ST_WRITE;
                        l_d.drive = 1'b0;
                    end
                end
                tmsp_pkg::ST_WRITE:
                begin
                    l_d.sh = shifted;
                    if (l_q.cnt == tmsp_pkg::LAST_BIT)
                    begin
                        l_d.st = tmsp_pkg::ST_ACK_WRITE;
                        l_d.drive = 1'b1;
                        if (l_q.first)
                        begin
                            l_d.ptr = shifted;
                            l_d.first = 1'b0;
                        end
                        else if (wr_hit)
                        begin
                            l_d.cfg[wr_slot] = shifted;
                        end
                        else if (l_q.ptr == tmsp_pkg::WA_ONE_SHOT)
                        begin
                            l_d.os_tog = ~l_q.os_tog;
                        end
                        // other addresses are acknowledged and dropped
                    end
                    else
                    begin
                        l_d.cnt = 3'(l_q.cnt + 3'h1);
                    end
                end
                tmsp_pkg::ST_ACK_WRITE:
                begin
                    l_d.st = tmsp_pkg::ST_WRITE;
                    l_d.cnt = 3'h0;
                    l_d.drive = 1'b0;
                end
                tmsp_pkg::ST_READ:
                begin
                    if (l_q.cnt == tmsp_pkg::LAST_BIT)
                    begin
                        l_d.st = tmsp_pkg::ST_READ_ACK;
                        l_d.drive = 1'b0;
                    end
                    else
                    begin
                        l_d.cnt = 3'(l_q.cnt + 3'h1);
                        l_d.tx = {l_q.tx[6:0], 1'b0};
                        l_d.drive = ~l_q.tx[6];
                    end
                end
                tmsp_pkg::ST_READ_ACK:
                begin
                    if (!bit_q)
                    begin
                        l_d.st = tmsp_pkg::ST_READ;
                        l_d.cnt = 3'h0;
                        l_d.tx = rd_byte;
                        l_d.drive = ~rd_byte[7];
                    end
                    else
                    begin
                        l_d.st = tmsp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(negedge scl_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            l_q <= '0;
            l_q.st <= tmsp_pkg::ST_IDLE;
            l_q.cfg <= tmsp_pkg::SLOT_RESET;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    // ************************************************************
    // bus timeout and one-shot, system clock side
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.act_s1 = l_q.act_gray;
        s_d.act_s2 = s_q.act_s1;
        s_d.act_s3 = s_q.act_s2;
        s_d.en_s1 = l_q.cfg[tmsp_pkg::SLOT_FAULT_FILTER][tmsp_pkg::TIMEOUT_EN_BIT];
        s_d.en_s2 = s_q.en_s1;
        s_d.os_s1 = l_q.os_tog;
        s_d.os_s2 = s_q.os_s1;
        s_d.os_s3 = s_q.os_s2;
        s_d.one_shot = s_q.os_s2 ^ s_q.os_s3;
        if (!s_q.en_s2 || (s_q.act_s2 != s_q.act_s3))
        begin
            s_d.cnt = '0;
            s_d.rel = 1'b0;
        end
        else if (!s_q.rel)
        begin
            if (s_q.cnt == TO_CNT_W'(TIMEOUT_CYC - 1))
                s_d.rel = 1'b1;
            else
                s_d.cnt = TO_CNT_W'(s_q.cnt + 1'b1);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = l_q.drive & ~s_q.rel;
    assign cfg_o = l_q.cfg;
    assign one_shot_o = s_q.one_shot;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_addr_match;
        l_q.st == tmsp_pkg::ST_ADDR && l_q.cnt == tmsp_pkg::LAST_BIT && shifted[7:1] == own_addr
            && start_tog_q == l_q.start_seen && stop_tog_q == l_q.stop_seen && !rel_hit;
    endsequence

    sequence s_last_write_bit;
        l_q.st == tmsp_pkg::ST_WRITE && l_q.cnt == tmsp_pkg::LAST_BIT
            && start_tog_q == l_q.start_seen && stop_tog_q == l_q.stop_seen && !rel_hit;
    endsequence

    a_addr_ack: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        s_addr_match |=> l_q.st == tmsp_pkg::ST_ACK_ADDR && l_q.drive)
        else $error("matching address not acknowledged");

    a_foreign_addr: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        (l_q.st == tmsp_pkg::ST_ADDR && l_q.cnt == tmsp_pkg::LAST_BIT && shifted[7:1] != own_addr
            && start_tog_q == l_q.start_seen) |=> l_q.st == tmsp_pkg::ST_IDLE && !l_q.drive)
        else $error("foreign address answered");

    a_ptr_load: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        (s_last_write_bit and l_q.first) |=> l_q.ptr == $past(shifted) && !l_q.first)
        else $error("first write byte not in pointer");

    a_reg_store: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        (s_last_write_bit and !l_q.first && wr_hit) |=> l_q.cfg[$past(wr_slot)] == $past(shifted))
        else $error("data byte not stored");

    a_ro_ignored: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        (s_last_write_bit and !l_q.first && !wr_hit) |=> $stable(l_q.cfg) && $stable(l_q.ptr))
        else $error("read-only write changed a register");

    a_read_byte: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        (l_q.st == tmsp_pkg::ST_ACK_ADDR && l_q.rw && start_tog_q == l_q.start_seen
            && stop_tog_q == l_q.stop_seen && !rel_hit)
        |=> (l_q.st == tmsp_pkg::ST_READ && l_q.tx == $past(rd_byte)) ##1 1'b1 [*7])
        else $error("read byte not loaded from pointer");

    a_start_restart: assert property (@(negedge scl_i) disable iff (sys_rst_i)
        (start_tog_q != l_q.start_seen) |=> l_q.st == tmsp_pkg::ST_ADDR && l_q.cnt == 3'h0 && !l_q.drive)
        else $error("start not restarting the engine");

    a_timeout_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !s_q.en_s2 |=> !s_q.rel && s_q.cnt == '0)
        else $error("timeout active while disabled");

    a_timeout_fire: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.en_s2 && !s_q.rel && s_q.act_s2 == s_q.act_s3 && s_q.cnt == TO_CNT_W'(TIMEOUT_CYC - 1))
        |=> s_q.rel && !sda_oe_o)
        else $error("timeout did not release data line");

    a_one_shot: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_q.os_s2 != s_q.os_s3) |=> one_shot_o ##1 !one_shot_o)
        else $error("one-shot pulse wrong");

    a_reset_values: assert property (@(posedge sys_clk_i)
        sys_rst_i |-> l_q.cfg == tmsp_pkg::SLOT_RESET)
        else $error("power-on defaults wrong");

endmodule

// >>> dv/tmsp_master.sv
// serial bus master model for the temperature monitor port
`timescale 1ns/1ps
module tmsp_master (
    output logic scl_o,
    output logic pull_o,
    input wire logic sda_i
);
    // ****
    // bus idles with clock high and data released
    // ****
    initial
    begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end

    // start or repeated start: data falls while clock high
    task automatic start();
        pull_o = 1'b0;
        #12 scl_o = 1'b1;
        #12 pull_o = 1'b1;
        #12 scl_o = 1'b0;
        #12;
    endtask

    // one clock pulse, data changed only while clock low
    task automatic clk_bit(input logic b, output logic r);
        pull_o = !b;
        #12 scl_o = 1'b1;
        #18 r = sda_i;
        #6 scl_o = 1'b0;
        #12;
    endtask

    // eight bits msb first plus acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic ack_d, output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(d[i], b);
            r[i] = b;
        end
        clk_bit(ack_d, ack);
    endtask

    // stop: data rises while clock high, clock then stands high
    task automatic stop();
        pull_o = 1'b1;
        #12 scl_o = 1'b1;
        #12 pull_o = 1'b0;
        #12;
    endtask
endmodule

// >>> dv/test_temp_monitor_serial_register_port.sv
// self-checking bench of the serial register port
`timescale 1ns/1ps
module test_temp_monitor_serial_register_port;
    localparam logic [7:0] ADW = {tmsp_pkg::DEV_ADDR_BASE, 1'b0};
    localparam logic [7:0] ADR = {tmsp_pkg::DEV_ADDR_BASE, 1'b1};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic addr_sel_i = 1'b0;
    logic scl;
    logic pull;
    logic sda_o;
    logic sda_oe;
    logic one_shot;
    tmsp_pkg::tmsp_meas_t meas = '{8'h19, 8'h2a, 8'hc0, 8'h80};
    tmsp_pkg::tmsp_cfg_t cfg;
    wire sda_w = !((sda_oe && !sda_o) || pull);
    int fails = 0;
    int compares = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    tmsp_port #(.TIMEOUT_CYC(50)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_sel_i(addr_sel_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .meas_i(meas), .cfg_o(cfg),
        .one_shot_o(one_shot));
    tmsp_master i_mst (.scl_o(scl), .pull_o(pull), .sda_i(sda_w));

    // ****
    // helpers
    // ****
    task automatic chk(input string n, input logic [111:0] e, input logic [111:0] g);
        compares++;
        if (e !== g)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic snd(input logic [7:0] d);
        logic [7:0] r;
        logic a;
        i_mst.xfer(d, 1'b1, r, a);
        chk("acknowledge", 1'b0, a);
    endtask

    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
        i_mst.start();
        snd(ADW);
        snd(p);
        snd(d);
        i_mst.stop();
    endtask

    task automatic rd_cur(output logic [7:0] d);
        logic a;
        i_mst.start();
        snd(ADR);
        i_mst.xfer(8'hff, 1'b1, d, a);
        i_mst.stop();
    endtask

    task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
        i_mst.start();
        snd(ADW);
        snd(p);
        rd_cur(d);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset();
        logic [7:0] ra [7] = '{8'h00, 8'h01, 8'h10, 8'h02, 8'hfe, 8'hff, 8'h30};
        logic [7:0] rv [7] = '{8'h19, 8'h2a, 8'hc0, 8'h80, tmsp_pkg::MAKER_ID, tmsp_pkg::REVISION_ID, 8'h00};
        logic [7:0] d;
        chk("data enable", 1'b0, sda_oe);
        chk("config", tmsp_pkg::SLOT_RESET, cfg);
        for (int s = 0; s < 14; s++)
        begin
            rd_reg(tmsp_pkg::SLOT_RD_ADDR[s], d);
            chk("reset value", tmsp_pkg::SLOT_RESET[s], d);
        end
        for (int i = 0; i < 7; i++)
        begin
            rd_reg(ra[i], d);
            chk("read only", rv[i], d);
            rd_cur(d);
            chk("reread", rv[i], d);
        end
    endtask

    task automatic t_rw();
        tmsp_pkg::tmsp_cfg_t e;
        logic [7:0] d;
        logic a;
        for (int s = 0; s < 14; s++)
        begin
            e[s] = 8'h10 + 8'(s);
            wr_reg(tmsp_pkg::SLOT_WR_ADDR[s], e[s]);
        end
        chk("config", e, cfg);
        for (int s = 0; s < 14; s++)
        begin
            rd_reg(tmsp_pkg::SLOT_RD_ADDR[s], d);
            chk("written", e[s], d);
        end
        rd_reg(8'h0d, d);
        chk("write address read", 8'h00, d);
        rd_reg(tmsp_pkg::SLOT_RD_ADDR[3], d);
        i_mst.start();
        snd(ADR);
        i_mst.xfer(8'hff, 1'b0, d, a);
        chk("first of two", e[3], d);
        i_mst.xfer(8'hff, 1'b1, d, a);
        chk("second of two", e[3], d);
        i_mst.stop();
    endtask

    task automatic t_ro();
        logic [7:0] wa [7] = '{8'h00, 8'h01, 8'h10, 8'h02, 8'hfe, 8'hff, 8'h30};
        tmsp_pkg::tmsp_cfg_t b;
        logic [7:0] d;
        logic a;
        b = cfg;
        for (int i = 0; i < 7; i++)
            wr_reg(wa[i], 8'h3c);
        chk("config", b, cfg);
        rd_reg(8'h01, d);
        chk("remote high", 8'h2a, d);
        i_mst.start();
        i_mst.xfer({tmsp_pkg::DEV_ADDR_ALT, 1'b0}, 1'b1, d, a);
        chk("foreign acknowledge", 1'b1, a);
        i_mst.stop();
        @(posedge sys_clk_i);
        #1 addr_sel_i = 1'b1;
        i_mst.start();
        i_mst.xfer({tmsp_pkg::DEV_ADDR_ALT, 1'b0}, 1'b1, d, a);
        chk("variant acknowledge", 1'b0, a);
        i_mst.stop();
        i_mst.start();
        i_mst.xfer(ADW, 1'b1, d, a);
        chk("base refused", 1'b1, a);
        i_mst.stop();
        @(posedge sys_clk_i);
        #1 addr_sel_i = 1'b0;
    endtask

    task automatic t_one_shot();
        tmsp_pkg::tmsp_cfg_t b;
        logic [7:0] d;
        int n;
        b = cfg;
        n = 0;
        wr_reg(tmsp_pkg::WA_ONE_SHOT, 8'h77);
        repeat (10)
        begin
            @(posedge sys_clk_i);
            #1;
            if (one_shot === 1'b1)
                n++;
        end
        chk("one shot pulses", 1, n);
        chk("config", b, cfg);
        rd_reg(tmsp_pkg::WA_ONE_SHOT, d);
        chk("one shot read", 8'h00, d);
    endtask

    task automatic t_timeout(input logic en);
        logic [7:0] r;
        logic a;
        if (en)
            wr_reg(8'h22, 8'h81);
        i_mst.start();
        for (int i = 7; i >= 0; i--)
            i_mst.clk_bit(ADW[i], a);
        repeat (80) @(posedge sys_clk_i);
        chk("data enable after idle", !en, sda_oe);
        i_mst.clk_bit(1'b1, a);
        i_mst.stop();
        rd_reg(8'h22, r);
        chk("filter", en ? 8'h81 : 8'h1d, r);
    endtask

    initial
    begin
        #1_000_000;
        fails++;
        end_sim();
    end

    initial
    begin
        #1 sys_rst_i = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        t_reset();
        t_rw();
        t_ro();
        t_one_shot();
        t_timeout(1'b0);
        t_timeout(1'b1);
        end_sim();
    end
endmodule
